// file: shared/dual_timer_pkg.sv
package dual_timer_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h18;
   localparam logic [7:0] ADDR_WAKE = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
   // Control field positions
   localparam int CASCADE_BIT = 31;
   localparam int B_CLKSEL_LO = 16;
   localparam int A_OUTB_BIT = 14;
   localparam int A_OUT_BIT = 13;
   localparam int A_WAKE_BIT = 12;
   localparam int A_SWCAP_BIT = 11;
   localparam int A_CAPSEL_LO = 9;
   localparam int A_IE_BIT = 8;
   localparam int A_NEG_BIT = 7;
   localparam int A_EVSEL_LO = 4;
   localparam int A_RDY_BIT = 3;
   localparam int A_CLKEN_BIT = 2;
   localparam int A_CLKSEL_LO = 0;
   // Wakeup flag positions and reset value
   localparam int WAKE_B_BIT = 16;
   localparam int WAKE_A_BIT = 0;
   localparam logic WAKE_RESET = 1'b1;
   // Interrupt status bits
   localparam int IRQ_EVT_BIT = 0;
   localparam int IRQ_CAP_BIT = 1;
   localparam int IRQ_WAKE_BIT = 2;
   localparam int IRQ_BITS = 3;
   // Clock ready synchroniser depth
   localparam int SYNC_STAGES = 2;
   // Register bus carrier
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;
   // Control fields
   typedef struct packed {
      logic cascade;
      logic [1:0] clkSelB;
      logic outBEn;
      logic outEn;
      logic wakeEnA;
      logic [1:0] capSelA;
      logic firstInterruptEnable;
      logic negTrigA;
      logic [2:0] eventSelA;
      logic clkEnA;
      logic [1:0] clkSelA;
   } ctrl_s;
endpackage : dual_timer_pkg

// file: design/edge_detect.sv
`timescale 1ns/1ps
// Edge detector with selectable polarity; input is sampled first
module edge_detect (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic sigIn,
   input wire logic fallSel,
   output logic edgePulse
);
   typedef struct packed {
      logic s0;
      logic s1;
   } ed_s;
   ed_s st_q, st_d;
   // Two samples: a level shorter than one clock may be missed
   always_comb begin
      st_d = st_q;
      st_d.s0 = sigIn;
      st_d.s1 = st_q.s0;
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign edgePulse = fallSel ? (st_q.s1 & ~st_q.s0) : (~st_q.s1 & st_q.s0);
endmodule : edge_detect

// file: design/dual_timer_control_wakeup.sv
`timescale 1ns/1ps
module dual_timer_control_wakeup
   import dual_timer_pkg::*;
#(
   parameter int MODE_W = 4
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic [MODE_W-1:0] timerMode,
   input wire logic [3:0] captureSrc,
   input wire logic eventIn,
   input wire logic wakeEventA,
   input wire logic wakeEventB,
   input wire logic outLevel,
   output logic [1:0] clkSelA,
   output logic [1:0] clkSelB,
   output logic cascadeMode,
   output logic clkReadyA,
   output logic captureStrobe,
   output logic eventStrobe,
   output logic timerOut,
   output logic timerOutN,
   output logic timerOutEn,
   output logic timerOutNEn,
   output logic irq
);
   typedef struct packed {
      ctrl_s ctrl;
      logic [SYNC_STAGES-1:0] rdySync;
      logic wakeA;
      logic wakeB;
      logic [IRQ_BITS-1:0] irqStat;
      logic [IRQ_BITS-1:0] irqMask;
      logic [31:0] rdata;
      logic [3:0] capPrev;
      logic cap;
      logic evt;
      logic out;
      logic outN;
      logic outEn;
      logic outNEn;
      logic irq;
   } state_s;

   state_s st_q, st_d;
   bus_req_s bus;
   logic edgeHit;

   // Field packing for readback
   function automatic logic [31:0] ctrl_word(input ctrl_s c, input logic rdy);
      logic [31:0] w;
      w = '0;
      w[CASCADE_BIT] = c.cascade;
      w[B_CLKSEL_LO +: 2] = c.clkSelB;
      w[A_OUTB_BIT] = c.outBEn;
      w[A_OUT_BIT] = c.outEn;
      w[A_WAKE_BIT] = c.wakeEnA;
      w[A_CAPSEL_LO +: 2] = c.capSelA;
      w[A_IE_BIT] = c.firstInterruptEnable;
      w[A_NEG_BIT] = c.negTrigA;
      w[A_EVSEL_LO +: 3] = c.eventSelA;
      w[A_RDY_BIT] = rdy;
      w[A_CLKEN_BIT] = c.clkEnA;
      w[A_CLKSEL_LO +: 2] = c.clkSelA;
      return w;
   endfunction : ctrl_word

   // Modes 2,4,6,8 drive the output on their own
   function automatic logic auto_out(input logic [MODE_W-1:0] m);
      return (m == MODE_W'(2)) || (m == MODE_W'(4)) || (m == MODE_W'(6)) || (m == MODE_W'(8));
   endfunction : auto_out

   assign bus.addr = regAddr;
   assign bus.wdata = regWdata;
   assign bus.wr = regWr;
   assign bus.rd = regRd;

   edge_detect u_edge (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .sigIn(eventIn),
      .fallSel(st_q.ctrl.negTrigA),
      .edgePulse(edgeHit)
   );

   // Next-state logic for all registers and outputs
   always_comb begin
      logic ctrlWr;
      logic [IRQ_BITS-1:0] irqSet;
      logic ready;
      ctrlWr = bus.wr && (bus.addr == ADDR_CTRL);
      irqSet = '0;
      ready = st_q.rdySync[SYNC_STAGES-1];
      st_d = st_q;
      st_d.rdata = '0;
      if (ctrlWr) begin
         st_d.ctrl.cascade = bus.wdata[CASCADE_BIT];
         st_d.ctrl.clkSelB = bus.wdata[B_CLKSEL_LO +: 2];
         st_d.ctrl.outBEn = bus.wdata[A_OUTB_BIT];
         st_d.ctrl.outEn = bus.wdata[A_OUT_BIT];
         st_d.ctrl.wakeEnA = bus.wdata[A_WAKE_BIT];
         st_d.ctrl.capSelA = bus.wdata[A_CAPSEL_LO +: 2];
         st_d.ctrl.firstInterruptEnable = bus.wdata[A_IE_BIT];
         st_d.ctrl.negTrigA = bus.wdata[A_NEG_BIT];
         st_d.ctrl.eventSelA = bus.wdata[A_EVSEL_LO +: 3];
         st_d.ctrl.clkEnA = bus.wdata[A_CLKEN_BIT];
         st_d.ctrl.clkSelA = bus.wdata[A_CLKSEL_LO +: 2];
      end
      // clock enable runs through the ready synchroniser
      // ready low while disabled or synchronising
      st_d.rdySync = {st_q.rdySync[SYNC_STAGES-2:0], st_q.ctrl.clkEnA};
      if (!st_q.ctrl.clkEnA) begin
         st_d.rdySync = '0;
      end
      // capture source edge from selected input
      st_d.capPrev = captureSrc;
      // software capture pulses, never stored as a level
      st_d.cap = ready && ((captureSrc[st_q.ctrl.capSelA] && !st_q.capPrev[st_q.ctrl.capSelA])
                 || (ctrlWr && bus.wdata[A_SWCAP_BIT]));
      // Event strobe only when an event source is selected
      st_d.evt = ready && edgeHit && (st_q.ctrl.eventSelA != 3'h0);
      st_d.outEn = ready && (st_q.ctrl.outEn || auto_out(timerMode));
      st_d.out = outLevel;
      st_d.outNEn = ready && st_q.ctrl.outBEn;
      st_d.outN = ~outLevel;
      // wakeup flags, set wins over clear
      if (bus.wr && (bus.addr == ADDR_WAKE)) begin
         if (bus.wdata[WAKE_A_BIT]) begin
            st_d.wakeA = 1'b0;
         end
         if (bus.wdata[WAKE_B_BIT]) begin
            st_d.wakeB = 1'b0;
         end
      end
      if (wakeEventA) begin
         st_d.wakeA = 1'b1;
      end
      if (wakeEventB) begin
         st_d.wakeB = 1'b1;
      end
      // Sticky interrupt status, write one to clear, set wins
      irqSet[IRQ_EVT_BIT] = st_d.evt;
      irqSet[IRQ_CAP_BIT] = st_d.cap;
      irqSet[IRQ_WAKE_BIT] = wakeEventA && st_q.ctrl.wakeEnA;
      if (bus.wr && (bus.addr == ADDR_IRQ_STAT)) begin
         st_d.irqStat = st_q.irqStat & ~bus.wdata[IRQ_BITS-1:0];
      end
      st_d.irqStat = st_d.irqStat | irqSet;
      if (bus.wr && (bus.addr == ADDR_IRQ_MASK)) begin
         st_d.irqMask = bus.wdata[IRQ_BITS-1:0];
      end
      // interrupt needs enable bit and pending event
      st_d.irq = st_q.ctrl.firstInterruptEnable && |(st_q.irqStat & st_q.irqMask);
      // Read data valid the cycle after the strobe; unmapped reads zero
      if (bus.rd) begin
         case (bus.addr)
            ADDR_CTRL: st_d.rdata = ctrl_word(st_q.ctrl, ready);
            ADDR_WAKE: begin
               st_d.rdata[WAKE_A_BIT] = st_q.wakeA;
               st_d.rdata[WAKE_B_BIT] = st_q.wakeB;
            end
            ADDR_IRQ_STAT: st_d.rdata[IRQ_BITS-1:0] = st_q.irqStat;
            ADDR_IRQ_MASK: st_d.rdata[IRQ_BITS-1:0] = st_q.irqMask;
            default: st_d.rdata = '0;
         endcase
      end
   end

   // State register; wakeup flags come out of reset set
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
         st_q.wakeA <= WAKE_RESET;
         st_q.wakeB <= WAKE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flops
   assign regRdata = st_q.rdata;
   assign clkSelA = st_q.ctrl.clkSelA;
   assign clkSelB = st_q.ctrl.clkSelB;
   assign cascadeMode = st_q.ctrl.cascade;
   assign clkReadyA = st_q.rdySync[SYNC_STAGES-1];
   assign captureStrobe = st_q.cap;
   assign eventStrobe = st_q.evt;
   assign timerOut = st_q.out;
   assign timerOutN = st_q.outN;
   assign timerOutEn = st_q.outEn;
   assign timerOutNEn = st_q.outNEn;
   assign irq = st_q.irq;

   // Rule checks; inputs appear in antecedents or under $past, consequents watch flops

   AST_RDY_DELAY: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(st_q.ctrl.clkEnA) |-> !clkReadyA ##1 !clkReadyA ##1 (clkReadyA == $past(st_q.ctrl.clkEnA)))
      else $error("clock ready timing wrong");

   AST_RDY_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
      !st_q.ctrl.clkEnA |=> !clkReadyA)
      else $error("clock ready while disabled");

   AST_RDY_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkReadyA && st_q.ctrl.clkEnA) |=> clkReadyA)
      else $error("clock ready dropped while enabled");

   AST_RDY_CLR: assert property (@(posedge sys_clk) disable iff (!resetn)
      (regWr && regAddr == ADDR_CTRL && !regWdata[A_CLKEN_BIT]) |=> ##1 !clkReadyA)
      else $error("clock ready kept after disable");

   AST_SWCAP: assert property (@(posedge sys_clk) disable iff (!resetn)
      (regWr && regAddr == ADDR_CTRL && regWdata[A_SWCAP_BIT] && clkReadyA) |=> captureStrobe)
      else $error("software capture missed");

   AST_CAP_GATED: assert property (@(posedge sys_clk) disable iff (!resetn)
      captureStrobe |-> $past(clkReadyA))
      else $error("capture strobe before clock ready");

   AST_CAP_SRC: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkReadyA && captureSrc[st_q.ctrl.capSelA] && !st_q.capPrev[st_q.ctrl.capSelA])
      |=> captureStrobe)
      else $error("selected capture source missed");

   AST_EVT_RISE: assert property (@(posedge sys_clk) disable iff (!resetn)
      (eventStrobe && !$past(st_q.ctrl.negTrigA)) |-> ($past(eventIn, 2) && !$past(eventIn, 3)))
      else $error("event strobe without rising edge");

   AST_EVT_FALL: assert property (@(posedge sys_clk) disable iff (!resetn)
      (eventStrobe && $past(st_q.ctrl.negTrigA)) |-> (!$past(eventIn, 2) && $past(eventIn, 3)))
      else $error("event strobe without falling edge");

   AST_OUT_AUTO: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkReadyA && auto_out(timerMode)) |=> timerOutEn)
      else $error("auto output not enabled");

   AST_OUT_BIT: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkReadyA && st_q.ctrl.outEn) |=> timerOutEn)
      else $error("output enable bit ignored");

   AST_OUT_GATE: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!st_q.ctrl.outEn && !auto_out(timerMode)) |=> !timerOutEn)
      else $error("output enabled without cause");

   AST_OUTN: assert property (@(posedge sys_clk) disable iff (!resetn)
      !st_q.ctrl.outBEn |=> !timerOutNEn)
      else $error("complementary output driven");

   AST_OUTN_ON: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clkReadyA && st_q.ctrl.outBEn) |=> timerOutNEn)
      else $error("complementary output not enabled");

   AST_WAKE_A: assert property (@(posedge sys_clk) disable iff (!resetn)
      wakeEventA |=> st_q.wakeA)
      else $error("wakeup A flag not set");

   AST_WAKE_A_CLR: assert property (@(posedge sys_clk) disable iff (!resetn)
      (regWr && regAddr == ADDR_WAKE && regWdata[WAKE_A_BIT] && !wakeEventA) |=> !st_q.wakeA)
      else $error("wakeup A flag not cleared");

   AST_WAKE_A_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!wakeEventA && !(regWr && regAddr == ADDR_WAKE && regWdata[WAKE_A_BIT]))
      |=> $stable(st_q.wakeA))
      else $error("wakeup A flag changed on its own");

   AST_WAKE_B: assert property (@(posedge sys_clk) disable iff (!resetn)
      wakeEventB |=> st_q.wakeB)
      else $error("wakeup B flag not set");

   AST_WAKE_CLR: assert property (@(posedge sys_clk) disable iff (!resetn)
      (regWr && regAddr == ADDR_WAKE && regWdata[WAKE_B_BIT] && !wakeEventB) |=> !st_q.wakeB)
      else $error("wakeup B flag not cleared");

   AST_WAKE_B_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!wakeEventB && !(regWr && regAddr == ADDR_WAKE && regWdata[WAKE_B_BIT]))
      |=> $stable(st_q.wakeB))
      else $error("wakeup B flag changed on its own");

   AST_IRQ: assert property (@(posedge sys_clk) disable iff (!resetn)
      irq |-> $past(st_q.ctrl.firstInterruptEnable))
      else $error("interrupt without enable");

   AST_IRQ_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st_q.ctrl.firstInterruptEnable && |(st_q.irqStat & st_q.irqMask)) |=> irq)
      else $error("interrupt missing");

   AST_IRQ_NONE: assert property (@(posedge sys_clk) disable iff (!resetn)
      !(|(st_q.irqStat & st_q.irqMask)) |=> !irq)
      else $error("interrupt without pending status");

   AST_CLKSEL: assert property (@(posedge sys_clk) disable iff (!resetn)
      (regWr && regAddr == ADDR_CTRL) |=> clkSelB == $past(regWdata[B_CLKSEL_LO +: 2])
         && clkSelA == $past(regWdata[A_CLKSEL_LO +: 2]))
      else $error("clock selector not stored");

   AST_CLKSEL_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
      !(regWr && regAddr == ADDR_CTRL) |=> $stable(clkSelA) && $stable(clkSelB))
      else $error("clock selector changed without write");

   AST_CASCADE: assert property (@(posedge sys_clk) disable iff (!resetn)
      (regWr && regAddr == ADDR_CTRL) |=> cascadeMode == $past(regWdata[CASCADE_BIT]))
      else $error("cascade bit not stored");
endmodule : dual_timer_control_wakeup

// file: bench/dual_timer_control_wakeup_test.sv
`timescale 1ns/1ps
// Case equality so an unknown never passes for a match
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin badCount++; \
   $display("ERROR %s expected %h seen %h", nm, (exp), (got)); end end
module dual_timer_control_wakeup_test;
   import dual_timer_pkg::*;
   localparam logic [31:0] CLKEN = 32'h0000_0004;
   localparam logic [31:0] SWCAP = 32'h0000_0800;
   localparam logic [31:0] IE = 32'h0000_0100;
   localparam logic [31:0] NEG = 32'h0000_0080;
   localparam logic [31:0] EVSEL = 32'h0000_0010;
   localparam logic [31:0] OUTEN = 32'h0000_2000;
   localparam logic [31:0] OUTB = 32'h0000_4000;
   logic sys_clk;
   logic resetn;
   logic [7:0] regAddr;
   logic [31:0] regWdata;
   logic regWr;
   logic regRd;
   logic [31:0] regRdata;
   logic [3:0] timerMode;
   logic [3:0] captureSrc;
   logic eventIn;
   logic wakeEventA;
   logic wakeEventB;
   logic outLevel;
   logic [1:0] clkSelA;
   logic [1:0] clkSelB;
   logic cascadeMode;
   logic clkReadyA;
   logic captureStrobe;
   logic eventStrobe;
   logic timerOut;
   logic timerOutN;
   logic timerOutEn;
   logic timerOutNEn;
   logic irq;
   int badCount = 0;
   int comparisons = 0;

   dual_timer_control_wakeup #(.MODE_W(4)) dut (.sys_clk(sys_clk), .resetn(resetn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .timerMode(timerMode), .captureSrc(captureSrc),
      .eventIn(eventIn), .wakeEventA(wakeEventA), .wakeEventB(wakeEventB),
      .outLevel(outLevel), .clkSelA(clkSelA), .clkSelB(clkSelB),
      .cascadeMode(cascadeMode), .clkReadyA(clkReadyA), .captureStrobe(captureStrobe),
      .eventStrobe(eventStrobe), .timerOut(timerOut), .timerOutN(timerOutN),
      .timerOutEn(timerOutEn), .timerOutNEn(timerOutNEn), .irq(irq));

   // 250 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Register write: one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : wr

   // Register read: data only stands in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      `CHK("regRdata", exp, regRdata)
   endtask : rdchk

   // Let registered outputs land before looking
   task automatic settle;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : settle

   // Count strobe cycles over a fixed window; pulses are one cycle wide
   task automatic pulses(input int sel, output int cnt);
      cnt = 0;
      repeat (8) begin
         #1;
         if ((sel == 0 ? captureStrobe : eventStrobe) === 1'b1) cnt++;
         @(posedge sys_clk);
      end
   endtask : pulses

   // Drive a capture source for three cycles (above the one-clock minimum), leave the event input at ev, and count strobes
   task automatic step(input int sel, input logic [3:0] src, input logic ev, input int exp);
      int n;
      fork
         pulses(sel, n);
         begin
            @(posedge sys_clk);
            captureSrc <= src;
            eventIn <= ev;
            repeat (3) @(posedge sys_clk);
            captureSrc <= 4'h0;
         end
      join
      `CHK("strobes", exp, n)
   endtask : step

   // Software capture write with strobe count
   task automatic swcap(input logic [31:0] d, input int exp);
      int n;
      fork
         pulses(0, n);
         wr(ADDR_CTRL, d);
      join
      `CHK("swCapture", exp, n)
   endtask : swcap

   task automatic testDone;
      $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : testDone

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #40000;
      badCount++;
      testDone();
   end

   // Main sequence
   initial begin
      logic [31:0] v;
      {regAddr, regWdata, regWr, regRd, timerMode, captureSrc} = '0;
      {eventIn, wakeEventA, wakeEventB, outLevel} = '0;
      resetn = 1'b0;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      rdchk(ADDR_WAKE, 32'h0001_0001);
      rdchk(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_WAKE, 32'h0000_0000);
      rdchk(ADDR_WAKE, 32'h0001_0001);
      wr(ADDR_WAKE, 32'h0000_0001);
      rdchk(ADDR_WAKE, 32'h0001_0000);
      wr(ADDR_WAKE, 32'h0001_0000);
      rdchk(ADDR_WAKE, 32'h0000_0000);
      @(posedge sys_clk) wakeEventB <= 1'b1;
      @(posedge sys_clk) wakeEventB <= 1'b0;
      settle();
      rdchk(ADDR_WAKE, 32'h0001_0000);
      @(posedge sys_clk) wakeEventA <= 1'b1;
      @(posedge sys_clk) wakeEventA <= 1'b0;
      settle();
      rdchk(ADDR_WAKE, 32'h0001_0001);
      rdchk(8'h30, 32'h0000_0000);
      // Capture is held off until the clock is ready
      swcap(SWCAP, 0);
      wr(ADDR_CTRL, CLKEN);
      #1;
      `CHK("clkReadyA", 1'b0, clkReadyA)
      settle();
      `CHK("clkReadyA", 1'b1, clkReadyA)
      rdchk(ADDR_CTRL, 32'h0000_000c);
      swcap(CLKEN | SWCAP, 1);
      rdchk(ADDR_CTRL, 32'h0000_000c);
      swcap(CLKEN, 0);
      // Capture status raises irq only with mask and enable both set
      rdchk(ADDR_IRQ_STAT, 32'h0000_0002);
      wr(ADDR_IRQ_MASK, 32'h0000_0002);
      settle();
      `CHK("irq", 1'b0, irq)
      wr(ADDR_CTRL, CLKEN | IE);
      settle();
      `CHK("irq", 1'b1, irq)
      wr(ADDR_IRQ_STAT, 32'h0000_0002);
      settle();
      `CHK("irq", 1'b0, irq)
      // Every clock option, cascade setting and capture source
      for (int k = 0; k < 4; k++) begin
         // Cascade only on odd passes, where both selectors carry the same option
         v = CLKEN | 32'(k) << 16 | 32'(k) << 9 | 32'(k % 2) << 31;
         v = v | 32'((k % 2 == 1) ? k : 2 - k);
         wr(ADDR_CTRL, v);
         settle();
         `CHK("clkSelB", 2'(k), clkSelB)
         `CHK("clkSelA", 2'((k % 2 == 1) ? k : 2 - k), clkSelA)
         `CHK("cascadeMode", 1'(k % 2), cascadeMode)
         rdchk(ADDR_CTRL, v | 32'h0000_0008);
         step(0, 4'h1 << k, 1'b0, 1);
         step(0, 4'h1 << ((k + 1) % 4), 1'b0, 0);
      end
      // Edge polarity; polarity is changed with time to settle first
      wr(ADDR_CTRL, CLKEN | EVSEL);
      step(1, 4'h0, 1'b1, 1);
      step(1, 4'h0, 1'b0, 0);
      wr(ADDR_CTRL, CLKEN | EVSEL | NEG);
      repeat (8) @(posedge sys_clk);
      step(1, 4'h0, 1'b1, 0);
      step(1, 4'h0, 1'b0, 1);
      // Automatic output modes ignore the enable bit
      wr(ADDR_CTRL, CLKEN);
      for (int m = 1; m <= 8; m++) begin
         @(posedge sys_clk) timerMode <= 4'(m);
         settle();
         `CHK("timerOutEn", 1'(m % 2 == 0), timerOutEn)
      end
      @(posedge sys_clk);
      timerMode <= 4'h1;
      outLevel <= 1'b1;
      wr(ADDR_CTRL, CLKEN | OUTEN | OUTB);
      settle();
      `CHK("timerOutEn", 1'b1, timerOutEn)
      `CHK("timerOutNEn", 1'b1, timerOutNEn)
      `CHK("timerOut", 1'b1, timerOut)
      `CHK("timerOutN", 1'b0, timerOutN)
      wr(ADDR_CTRL, CLKEN | OUTEN);
      settle();
      `CHK("timerOutNEn", 1'b0, timerOutNEn)
      wr(ADDR_CTRL, 32'h0000_0000);
      settle();
      `CHK("timerOutEn", 1'b0, timerOutEn)
      `CHK("clkReadyA", 1'b0, clkReadyA)
      // A wakeup with its function enabled raises the wakeup status bit
      wr(ADDR_IRQ_STAT, 32'h0000_0007);
      wr(ADDR_CTRL, 32'h0000_1000);
      @(posedge sys_clk) wakeEventA <= 1'b1;
      @(posedge sys_clk) wakeEventA <= 1'b0;
      settle();
      rdchk(ADDR_IRQ_STAT, 32'h0000_0004);
      testDone();
   end
endmodule : dual_timer_control_wakeup_test
